// ### hw/cfci_fault_irq.sv
// Fault confinement, event flags and buffer completion flags behind an APB slave.
`timescale 1ns/1ps
`include "cfci_defs.svh"

// Overview of operation
// R1: Entering bus-off sets the bus-off flag; interrupt only when its enable is set.
// R2: Reset leaves the bus-off flag clear; only a later bus-off entry sets it.
// R3: Writing one to bus-off, error or wake flag changes nothing.
// R4: Any error status bit event sets the error flag; interrupt gated by enable.
// R5: In sleep with stop set, recessive-to-dominant edge sets wake flag if enabled.
// R6: Sixteen buffer mask bits; a set bit enables that buffer's interrupt.
// R7: Buffer interrupt follows mask at once; setting or clearing mask changes it.
// R8: Mask and flag registers take 16-bit access and separate byte access.
// R9: Each buffer completion sets its flag; interrupt when its mask bit is set.
// R10: A completion during read-then-clear keeps the flag set.
// R11: Buffer flags reset to zero; writes only clear, never set.
// R12: Eight-bit counters: reset zero, add eight (receive also one), subtract one, floor zero.
// R13: Receive counter holds above 127; next good reception loads 119.
// R14: Counters are read-only unless test mode is set.
// R15: Either counter at 128 or more makes the state error-passive.
// R16: Error-passive returns to error-active when both counters are 127 or less.
// R17: Transmit counter reaching 256 enters bus-off and clears transmit counter.
// R18: Bus-off counts 11-recessive groups into transmit counter; at 128 recover, clear both.
// R19: A dominant bit before 11 recessive clears the run count only.
// R20: Error flag kind follows state, passive delays start, bus-off drives nothing.
// R21: Acknowledge errors while passive never push the node into bus-off.
// R22: Software clears an event flag by reading one, then writing zero.
// R23: Fault field reads 00 active, 01 passive, 10 bus-off.
// R24: Each event interrupt is its flag AND its enable, held until cleared.
module cfci_fault_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cfci_pkg::cfci_evt_t evt,
  input wire logic [15:0] buffer_done,
  input wire logic bit_tick,
  input wire logic rx_bit,
  output cfci_pkg::cfci_bus_ctl_t bus_ctl,
  output logic [1:0] fault_state,
  output logic busoff_irq,
  output logic error_irq,
  output logic wake_irq,
  output logic buffer_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  cfci_pkg::cfci_fault_t state_reg, state_next;
  logic [7:0] tec_reg, tec_next;
  logic [7:0] rec_reg, rec_next;
  logic [3:0] run_reg, run_next;
  logic [2:0] evflag_reg, evflag_next;
  logic [2:0] evarm_reg, evarm_next;
  logic [5:0] errbits_reg, errbits_next;
  logic [15:0] buffer_irq_enable_reg, buffer_irq_enable_next;
  logic [15:0] buffer_done_flag_reg, buffer_done_flag_next;
  logic [15:0] bufarm_reg, bufarm_next;
  logic [7:0] control_reg_zero_reg, control_reg_zero_next;
  logic [7:0] module_config_reg_reg, module_config_reg_next;
  logic rx_prev_reg, rx_prev_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [1:0] fault_next;
  cfci_pkg::cfci_bus_ctl_t bus_ctl_reg, bus_ctl_next;
  logic [3:0] irq_reg, irq_next;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic [5:0] idx;
  logic hit, wr_done, rd_done;
  logic [15:0] lane_wr, lane_rd, wr_half;
  logic [8:0] tec_sum, rec_sum;
  logic [15:0] flag_clear;
  logic [2:0] ev_clear, ev_set;
  logic test_mode, wake_edge;

  assign idx = paddr[7:2];
  assign wr_done = psel & penable & pready_reg & pwrite;
  assign rd_done = psel & penable & pready_reg & ~pwrite;
  assign test_mode = module_config_reg_reg[`CFCI_CFG_TEST];

  always_comb begin
    hit = (idx >= `CFCI_IDX_MASK_HIGH) && (idx <= `CFCI_IDX_FLAG16) && (paddr[1:0] == 2'b00);
  end

  // R8: byte and half-word views of the mask and flag words.
  always_comb begin
    lane_wr = 16'h0000;
    wr_half = 16'h0000;
    if (idx == `CFCI_IDX_MASK_HIGH || idx == `CFCI_IDX_FLAG_HIGH) begin
      lane_wr = {{8{pstrb[0]}}, 8'h00};
      wr_half = {pwdata[7:0], 8'h00};
    end else if (idx == `CFCI_IDX_MASK_LOW || idx == `CFCI_IDX_FLAG_LOW) begin
      lane_wr = {8'h00, {8{pstrb[0]}}};
      wr_half = {8'h00, pwdata[7:0]};
    end else if (idx == `CFCI_IDX_MASK16 || idx == `CFCI_IDX_FLAG16) begin
      lane_wr = {{8{pstrb[1]}}, {8{pstrb[0]}}};
      wr_half = pwdata[15:0];
    end
    lane_rd = 16'hFFFF;
    if (idx == `CFCI_IDX_FLAG_HIGH) begin
      lane_rd = 16'hFF00;
    end else if (idx == `CFCI_IDX_FLAG_LOW) begin
      lane_rd = 16'h00FF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file next values.
  logic is_flag, is_mask;
  assign is_flag = (idx == `CFCI_IDX_FLAG_HIGH) || (idx == `CFCI_IDX_FLAG_LOW) ||
                   (idx == `CFCI_IDX_FLAG16);
  assign is_mask = (idx == `CFCI_IDX_MASK_HIGH) || (idx == `CFCI_IDX_MASK_LOW) ||
                   (idx == `CFCI_IDX_MASK16);

  always_comb begin
    pready_next = psel & ~penable;
    pslverr_next = psel & ~penable & ~hit;
    prdata_next = 32'h0000_0000;
    if (psel & ~penable) begin
      unique case (idx)
        `CFCI_IDX_MASK_HIGH: prdata_next[7:0] = buffer_irq_enable_reg[15:8];
        `CFCI_IDX_MASK_LOW: prdata_next[7:0] = buffer_irq_enable_reg[7:0];
        `CFCI_IDX_FLAG_HIGH: prdata_next[7:0] = buffer_done_flag_reg[15:8];
        `CFCI_IDX_FLAG_LOW: prdata_next[7:0] = buffer_done_flag_reg[7:0];
        `CFCI_IDX_RX_COUNT: prdata_next[7:0] = rec_reg;
        `CFCI_IDX_TX_COUNT: prdata_next[7:0] = tec_reg;
        `CFCI_IDX_CTRL_ZERO: prdata_next[7:0] = control_reg_zero_reg;
        `CFCI_IDX_MODULE_CFG: prdata_next[7:0] = module_config_reg_reg;
        `CFCI_IDX_MASK16: prdata_next[15:0] = buffer_irq_enable_reg;
        `CFCI_IDX_FLAG16: prdata_next[15:0] = buffer_done_flag_reg;
        `CFCI_IDX_STATUS: begin
          prdata_next[`CFCI_ST_ERRBITS_LO +: 6] = errbits_reg;
          prdata_next[`CFCI_ST_FAULT_LO +: 2] = fault_state;
          prdata_next[2:0] = evflag_reg;
        end
        default: prdata_next = 32'h0000_0000;
      endcase
    end
    control_reg_zero_next = control_reg_zero_reg;
    module_config_reg_next = module_config_reg_reg;
    buffer_irq_enable_next = buffer_irq_enable_reg;
    if (wr_done && idx == `CFCI_IDX_CTRL_ZERO && pstrb[0]) begin
      control_reg_zero_next = pwdata[7:0];
    end
    if (wr_done && idx == `CFCI_IDX_MODULE_CFG && pstrb[0]) begin
      module_config_reg_next = pwdata[7:0];
    end
    // R6: per-buffer enables, byte or half-word written.
    if (wr_done && is_mask) begin
      buffer_irq_enable_next = (buffer_irq_enable_reg & ~lane_wr) | (wr_half & lane_wr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer completion flags.
  assign flag_clear = (wr_done && is_flag) ? (bufarm_reg & lane_wr & ~wr_half) : 16'h0000;

  genvar b;
  generate
    for (b = 0; b < 16; b++) begin : g_buf
      always_comb begin
        // R10: a new completion wins over the pending clear.
        // R11: a written one never sets a flag.
        // R9: completion sets the flag.
        buffer_done_flag_next[b] = buffer_done[b] |
                                   (buffer_done_flag_reg[b] & ~flag_clear[b]);
        bufarm_next[b] = bufarm_reg[b];
        if (rd_done && is_flag && lane_rd[b]) begin
          bufarm_next[b] = buffer_done_flag_reg[b];
        end
        if (flag_clear[b] || buffer_done[b]) begin
          bufarm_next[b] = 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Event flags: bit 2 bus-off, bit 1 error, bit 0 wake.
  // R5: edge seen only in sleep with stop set and wake enabled.
  assign wake_edge = module_config_reg_reg[`CFCI_CFG_STOP] &
                     module_config_reg_reg[`CFCI_CFG_WAKE_EN] & rx_prev_reg & ~rx_bit;

  always_comb begin
    ev_set = 3'b000;
    // R1: flag on each entry into bus-off.
    ev_set[`CFCI_ST_BUSOFF] = (state_next == cfci_pkg::CFCI_BUSOFF) &&
                              (state_reg != cfci_pkg::CFCI_BUSOFF);
    // R4: every error status event, already set or not.
    ev_set[`CFCI_ST_ERROR] = |evt.err_bits;
    ev_set[`CFCI_ST_WAKE] = wake_edge;
    // R22: read-as-one arms, written zero then clears.
    // R3: a written one clears nothing.
    ev_clear = (wr_done && idx == `CFCI_IDX_STATUS && pstrb[0]) ?
               (evarm_reg & ~pwdata[2:0]) : 3'b000;
    evflag_next = ev_set | (evflag_reg & ~ev_clear);
    evarm_next = evarm_reg & ~(ev_clear | ev_set);
    errbits_next = errbits_reg | evt.err_bits;
    if (rd_done && idx == `CFCI_IDX_STATUS) begin
      evarm_next = evflag_reg & ~ev_set;
      // Error reports accumulate since the last status read.
      errbits_next = evt.err_bits;
    end
    rx_prev_next = rx_bit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error counters and fault state.
  always_comb begin
    state_next = state_reg;
    tec_next = tec_reg;
    rec_next = rec_reg;
    run_next = run_reg;
    tec_sum = {1'b0, tec_reg};
    rec_sum = {1'b0, rec_reg};
    unique case (state_reg)
      cfci_pkg::CFCI_BUSOFF: begin
        if (bit_tick) begin
          if (rx_bit) begin
            // R18: wrap after each group of recessive bits.
            if (run_reg == `CFCI_RECESSIVE_RUN - 4'h1) begin
              run_next = 4'h0;
              tec_next = tec_reg + 8'h01;
              if (tec_next == `CFCI_RECOVERY_GROUPS) begin
                state_next = cfci_pkg::CFCI_ACTIVE;
                tec_next = 8'h00;
                rec_next = 8'h00;
              end
            end else begin
              run_next = run_reg + 4'h1;
            end
          end else begin
            // R19: dominant bit restarts the run only.
            run_next = 4'h0;
          end
        end
      end
      cfci_pkg::CFCI_ACTIVE, cfci_pkg::CFCI_PASSIVE: begin
        run_next = 4'h0;
        // R12: step sizes and floor at zero.
        // R21: acknowledge errors while passive add nothing.
        if (evt.tx_err && !(evt.ack_err && state_reg == cfci_pkg::CFCI_PASSIVE)) begin
          tec_sum = tec_sum + `CFCI_STEP_BIG;
        end
        if (evt.tx_ok && tec_sum != 9'h000) begin
          tec_sum = tec_sum - `CFCI_STEP_ONE;
        end
        if (evt.rx_ok) begin
          // R13: reload from the held range, else count down.
          if (rec_reg > `CFCI_RX_HOLD) begin
            rec_sum = {1'b0, `CFCI_RX_PRESET};
          end else if (rec_reg != 8'h00) begin
            rec_sum = rec_sum - `CFCI_STEP_ONE;
          end
        end else if (rec_reg <= `CFCI_RX_HOLD) begin
          // R13: no increase once above the hold limit.
          if (evt.rx_err_big) begin
            rec_sum = rec_sum + `CFCI_STEP_BIG;
          end else if (evt.rx_err) begin
            rec_sum = rec_sum + `CFCI_STEP_ONE;
          end
        end
        rec_next = rec_sum[7:0];
        if (tec_sum >= `CFCI_BUSOFF_LIMIT) begin
          // R17: bus-off entry clears the transmit counter.
          state_next = cfci_pkg::CFCI_BUSOFF;
          tec_next = 8'h00;
        end else begin
          tec_next = tec_sum[7:0];
          // R15: passive at 128 or more.
          // R16: active when both are 127 or less.
          if (tec_sum >= `CFCI_PASSIVE_LIMIT || rec_sum >= `CFCI_PASSIVE_LIMIT) begin
            state_next = cfci_pkg::CFCI_PASSIVE;
          end else begin
            state_next = cfci_pkg::CFCI_ACTIVE;
          end
        end
      end
      default: state_next = cfci_pkg::CFCI_ACTIVE;
    endcase
    // R14: counters writable only in test mode; the write wins over counting.
    if (wr_done && test_mode && pstrb[0]) begin
      if (idx == `CFCI_IDX_RX_COUNT) begin
        rec_next = pwdata[7:0];
      end
      if (idx == `CFCI_IDX_TX_COUNT) begin
        tec_next = pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, registered from next values so they move with the state.
  always_comb begin
    // R23: fault field encoding.
    unique case (state_next)
      cfci_pkg::CFCI_PASSIVE: fault_next = 2'b01;
      cfci_pkg::CFCI_BUSOFF: fault_next = 2'b10;
      default: fault_next = 2'b00;
    endcase
    // R20: bus behaviour per fault state.
    bus_ctl_next.drive_enable = (state_next != cfci_pkg::CFCI_BUSOFF);
    bus_ctl_next.passive_flags = (state_next == cfci_pkg::CFCI_PASSIVE);
    bus_ctl_next.delay_start = (state_next == cfci_pkg::CFCI_PASSIVE);
    // R24: each event interrupt is flag AND enable.
    irq_next[0] = evflag_next[`CFCI_ST_BUSOFF] & control_reg_zero_next[`CFCI_CTRL_BUSOFF_EN];
    irq_next[1] = evflag_next[`CFCI_ST_ERROR] & control_reg_zero_next[`CFCI_CTRL_ERROR_EN];
    irq_next[2] = evflag_next[`CFCI_ST_WAKE] & module_config_reg_next[`CFCI_CFG_WAKE_EN];
    // R7: the mask takes effect in the same edge that writes it.
    irq_next[3] = |(buffer_done_flag_next & buffer_irq_enable_next);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  // R2: flags, counters, masks and enables start clear, the bus-off flag included.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cfci_pkg::CFCI_ACTIVE;
      tec_reg <= `CFCI_RESET_BYTE;
      rec_reg <= `CFCI_RESET_BYTE;
      run_reg <= 4'h0;
      evflag_reg <= 3'b000;
      evarm_reg <= 3'b000;
      errbits_reg <= 6'h00;
      buffer_irq_enable_reg <= `CFCI_RESET_HALF;
      buffer_done_flag_reg <= `CFCI_RESET_HALF;
      bufarm_reg <= `CFCI_RESET_HALF;
      control_reg_zero_reg <= `CFCI_RESET_BYTE;
      module_config_reg_reg <= `CFCI_RESET_BYTE;
      rx_prev_reg <= 1'b1;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      fault_state <= 2'b00;
      bus_ctl_reg <= 3'b100;
      irq_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      tec_reg <= tec_next;
      rec_reg <= rec_next;
      run_reg <= run_next;
      evflag_reg <= evflag_next;
      evarm_reg <= evarm_next;
      errbits_reg <= errbits_next;
      buffer_irq_enable_reg <= buffer_irq_enable_next;
      buffer_done_flag_reg <= buffer_done_flag_next;
      bufarm_reg <= bufarm_next;
      control_reg_zero_reg <= control_reg_zero_next;
      module_config_reg_reg <= module_config_reg_next;
      rx_prev_reg <= rx_prev_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      fault_state <= fault_next;
      bus_ctl_reg <= bus_ctl_next;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign bus_ctl = bus_ctl_reg;
  assign busoff_irq = irq_reg[0];
  assign error_irq = irq_reg[1];
  assign wake_irq = irq_reg[2];
  assign buffer_irq = irq_reg[3];

endmodule : cfci_fault_irq

// ### hw/cfci_defs.svh
// Register indices, field positions, reset values and counter limits of the fault block.
`ifndef CFCI_DEFS_SVH
`define CFCI_DEFS_SVH

// Register indices; the byte address is four times the index.
`define CFCI_IDX_MASK_HIGH 6'h22
`define CFCI_IDX_MASK_LOW 6'h23
`define CFCI_IDX_FLAG_HIGH 6'h24
`define CFCI_IDX_FLAG_LOW 6'h25
`define CFCI_IDX_RX_COUNT 6'h26
`define CFCI_IDX_TX_COUNT 6'h27
`define CFCI_IDX_CTRL_ZERO 6'h28
`define CFCI_IDX_STATUS 6'h29
`define CFCI_IDX_MODULE_CFG 6'h2A
`define CFCI_IDX_MASK16 6'h2B
`define CFCI_IDX_FLAG16 6'h2C

// Control register zero fields.
`define CFCI_CTRL_BUSOFF_EN 0
`define CFCI_CTRL_ERROR_EN 1
// Module configuration fields.
`define CFCI_CFG_STOP 0
`define CFCI_CFG_WAKE_EN 1
`define CFCI_CFG_TEST 2
// Status fields.
`define CFCI_ST_WAKE 0
`define CFCI_ST_ERROR 1
`define CFCI_ST_BUSOFF 2
`define CFCI_ST_FAULT_LO 4
`define CFCI_ST_ERRBITS_LO 10

`define CFCI_RESET_BYTE 8'h00
`define CFCI_RESET_HALF 16'h0000

// Counter limits.
`define CFCI_PASSIVE_LIMIT 9'h080
`define CFCI_BUSOFF_LIMIT 9'h100
`define CFCI_RX_PRESET 8'h77
`define CFCI_RX_HOLD 8'h7F
`define CFCI_RECESSIVE_RUN 4'hB
`define CFCI_RECOVERY_GROUPS 8'h80
`define CFCI_STEP_BIG 9'h008
`define CFCI_STEP_ONE 9'h001

`endif

// ### hw/cfci_pkg.sv
// Types shared by the fault-confinement and interrupt block.
package cfci_pkg;

  typedef enum logic [2:0] {
    CFCI_ACTIVE = 3'b001,
    CFCI_PASSIVE = 3'b010,
    CFCI_BUSOFF = 3'b100
  } cfci_fault_t;

  // One-cycle events from the protocol engine.
  typedef struct packed {
    logic tx_err;
    logic ack_err;
    logic tx_ok;
    logic rx_err;
    logic rx_err_big;
    logic rx_ok;
    logic [5:0] err_bits;
  } cfci_evt_t;

  // Bus-side controls toward the protocol engine.
  typedef struct packed {
    logic drive_enable;
    logic passive_flags;
    logic delay_start;
  } cfci_bus_ctl_t;

endpackage : cfci_pkg

// ### bench/cfci_bus_node.sv
// Far-side bus model: bursts of bit times at one level, recessive bus between bursts.
`timescale 1ns/1ps
module cfci_bus_node (
  input logic pclk,
  input logic presetn,
  input logic go,
  input logic level,
  input logic [11:0] count,
  output logic bit_tick,
  output logic rx_bit,
  output logic busy
);
  logic [11:0] left_reg;
  logic [1:0] div_reg;
  logic lvl_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_reg <= 12'h000;
      div_reg <= 2'h0;
      lvl_reg <= 1'b1;
    end else if (go) begin
      left_reg <= count;
      div_reg <= 2'h0;
      lvl_reg <= level;
    end else if (left_reg != 12'h000) begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3) begin
        left_reg <= left_reg - 12'h001;
      end
    end
  end

  assign busy = (left_reg != 12'h000);
  // The bit clock stands still between bursts, and the pulled-up bus then reads recessive.
  assign bit_tick = busy && (div_reg == 2'h3);
  assign rx_bit = busy ? lvl_reg : 1'b1;
endmodule : cfci_bus_node

// ### bench/cfci_fault_checker.sv
// Port-level assertions for the fault-confinement and interrupt block.
`timescale 1ns/1ps
module cfci_fault_checker (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input cfci_pkg::cfci_evt_t evt,
  input logic [15:0] buffer_done,
  input logic bit_tick,
  input logic rx_bit,
  input cfci_pkg::cfci_bus_ctl_t bus_ctl,
  input logic [1:0] fault_state,
  input logic busoff_irq,
  input logic error_irq,
  input logic wake_irq,
  input logic buffer_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wc;
  // Any write commit may legally move a flag, enable or mask.
  assign wc = psel & penable & pwrite;

  ////////////////////////////////////////////////////////////////////////////////
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_answer;
    pready ##1 !pready;
  endsequence

  a_ready_timing: assert property (apb_setup |=> apb_answer)
    else $error("late bus answer");
  a_busoff_entry: assert property ($rose(fault_state[1]) |-> $past(evt.tx_err))
    else $error("bus-off without tx error");
  a_busoff_quiet: assert property (fault_state[1] |-> !bus_ctl.drive_enable)
    else $error("bus driven while bus-off");
  a_passive_ctl: assert property (fault_state == 2'b01 |-> bus_ctl == 3'b111)
    else $error("passive controls wrong");
  a_fault_code: assert property (fault_state != 2'b11)
    else $error("fault code out of range");
  a_error_cause: assert property ($rose(error_irq) |-> $past(|evt.err_bits) || $past(wc))
    else $error("error irq without cause");
  a_error_held: assert property (error_irq && !wc |=> error_irq)
    else $error("error irq dropped");
  a_wake_held: assert property (wake_irq && !wc |=> wake_irq)
    else $error("wake irq dropped");
  a_wake_cause: assert property ($rose(wake_irq) |-> !$past(rx_bit) || $past(wc))
    else $error("wake irq without edge");
  a_buffer_cause: assert property ($rose(buffer_irq) |-> $past(|buffer_done) || $past(wc))
    else $error("buffer irq without cause");
  a_recover_gate: assert property (fault_state[1] && !bit_tick && !wc |=> fault_state[1])
    else $error("left bus-off untimed");
  a_busoff_irq_cause: assert property ($rose(busoff_irq) |-> $rose(fault_state[1]) || $past(wc))
    else $error("bus-off irq without entry");
endmodule : cfci_fault_checker

bind cfci_fault_irq cfci_fault_checker i_cfci_fault_checker (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .evt, .buffer_done, .bit_tick, .rx_bit, .bus_ctl, .fault_state,
  .busoff_irq, .error_irq, .wake_irq, .buffer_irq);

// ### bench/tb.sv
// Self-checking testbench for the fault-confinement and interrupt block.
`timescale 1ns/1ps
`include "cfci_defs.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, er, go, level;
  logic pready, pslverr, bit_tick, rx_bit, busy;
  logic busoff_irq, error_irq, wake_irq, buffer_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [15:0] buffer_done, msk, done;
  logic [11:0] count;
  logic [1:0] fault_state;
  cfci_pkg::cfci_evt_t evt;
  cfci_pkg::cfci_bus_ctl_t bus_ctl;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 79;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} cfci_note_t;
  cfci_note_t notes[$];
  cfci_note_t note;

  cfci_fault_irq i_cfci_fault_irq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .evt, .buffer_done, .bit_tick, .rx_bit, .bus_ctl,
    .fault_state, .busoff_irq, .error_irq, .wake_irq, .buffer_irq);
  cfci_bus_node i_cfci_bus_node (.pclk, .presetn, .go, .level, .count, .bit_tick, .rx_bit,
    .busy);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1) begin
      @(negedge pclk);
      n++;
    end
    check(n, 0, "no bus answer");
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs launched by the committing edge are looked at only once settled.
    @(negedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, m);
    notes.push_back('{exp, m});
    apb(1'b0, idx, 32'h0000_0000);
  endtask : rd_chk

  task automatic pulse(input logic [11:0] e, input logic [15:0] d);
    @(posedge pclk);
    evt <= cfci_pkg::cfci_evt_t'(e);
    buffer_done <= d;
    @(posedge pclk);
    evt <= 12'h000;
    buffer_done <= 16'h0000;
    @(negedge pclk);
  endtask : pulse

  task automatic burst(input logic lvl, input logic [11:0] n);
    @(posedge pclk);
    go <= 1'b1;
    level <= lvl;
    count <= n;
    @(posedge pclk);
    go <= 1'b0;
    @(negedge pclk);
    while (busy) begin
      @(negedge pclk);
    end
  endtask : burst

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      note = notes.pop_front();
      check(prdata & note.m, note.v & note.m, "read data");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Five times the expected run length means a hang.
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    results();
  end

  initial begin
    {presetn, psel, penable, pwrite, go, level} = 6'h01;
    {paddr, pwdata, pstrb, count} = {8'h00, 32'h0, 4'hF, 12'h000};
    evt = 12'h000;
    buffer_done = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_chk(`CFCI_IDX_MASK_HIGH + i[5:0], 32'h0, 32'hFF);
    end
    rd_chk(`CFCI_IDX_STATUS, 32'h0, 32'h37);
    check({busoff_irq, error_irq, wake_irq, buffer_irq}, 32'h0, "irq after reset");
    rd_chk(6'h3F, 32'h0, 32'hFFFF_FFFF);
    check(32'(er), 32'h1, "unmapped error");
    msk = 16'($random(seed));
    done = 16'($random(seed)) | 16'h0101;
    apb(1'b1, `CFCI_IDX_MASK16, {16'h0, msk});
    rd_chk(`CFCI_IDX_MASK_HIGH, {24'h0, msk[15:8]}, 32'hFF);
    rd_chk(`CFCI_IDX_MASK_LOW, {24'h0, msk[7:0]}, 32'hFF);
    pulse(12'h000, done);
    check(32'(buffer_irq), 32'(|(done & msk)), "buffer irq");
    apb(1'b1, `CFCI_IDX_FLAG16, 32'hFFFF);
    rd_chk(`CFCI_IDX_FLAG16, {16'h0, done}, 32'hFFFF);
    apb(1'b1, `CFCI_IDX_MASK_HIGH, 32'h00);
    apb(1'b1, `CFCI_IDX_MASK_LOW, 32'hFF);
    check(32'(buffer_irq), 32'h1, "mask set");
    apb(1'b1, `CFCI_IDX_MASK_LOW, 32'h00);
    check(32'(buffer_irq), 32'h0, "mask cleared");
    pulse(12'h000, 16'h0100);
    apb(1'b1, `CFCI_IDX_FLAG16, 32'h0);
    rd_chk(`CFCI_IDX_FLAG16, 32'h0100, 32'hFFFF);
    apb(1'b1, `CFCI_IDX_MASK16, 32'h0100);
    check(32'(buffer_irq), 32'h1, "buffer irq kept");
    apb(1'b1, `CFCI_IDX_FLAG_HIGH, 32'h00);
    rd_chk(`CFCI_IDX_FLAG16, 32'h0, 32'hFFFF);
    check(32'(buffer_irq), 32'h0, "buffer irq cleared");
    apb(1'b1, `CFCI_IDX_CTRL_ZERO, 32'h3);
    pulse(12'h004, 16'h0);
    check(32'(error_irq), 32'h1, "error irq");
    apb(1'b1, `CFCI_IDX_STATUS, 32'h7);
    check(32'(error_irq), 32'h1, "write one kept");
    rd_chk(`CFCI_IDX_STATUS, 32'h1002, 32'hFC07);
    pulse(12'h004, 16'h0);
    apb(1'b1, `CFCI_IDX_STATUS, 32'h0);
    check(32'(error_irq), 32'h1, "error set again");
    rd_chk(`CFCI_IDX_STATUS, 32'h1002, 32'hFC07);
    apb(1'b1, `CFCI_IDX_STATUS, 32'h0);
    check(32'(error_irq), 32'h0, "error cleared");
    repeat (16) begin
      pulse(12'h080, 16'h0);
    end
    check(32'(fault_state), 32'h1, "passive");
    check(32'(bus_ctl), 32'h7, "passive controls");
    pulse(12'h080, 16'h0);
    rd_chk(`CFCI_IDX_RX_COUNT, 32'h80, 32'hFF);
    pulse(12'h040, 16'h0);
    rd_chk(`CFCI_IDX_RX_COUNT, 32'h77, 32'hFF);
    check(32'(fault_state), 32'h0, "active again");
    pulse(12'h040, 16'h0);
    pulse(12'h100, 16'h0);
    pulse(12'h200, 16'h0);
    pulse(12'h800, 16'h0);
    rd_chk(`CFCI_IDX_RX_COUNT, 32'h77, 32'hFF);
    rd_chk(`CFCI_IDX_TX_COUNT, 32'h08, 32'hFF);
    apb(1'b1, `CFCI_IDX_TX_COUNT, 32'h55);
    rd_chk(`CFCI_IDX_TX_COUNT, 32'h08, 32'hFF);
    apb(1'b1, `CFCI_IDX_MODULE_CFG, 32'h4);
    apb(1'b1, `CFCI_IDX_TX_COUNT, 32'h80);
    pulse(12'hC00, 16'h0);
    check(32'(fault_state), 32'h1, "tx passive");
    rd_chk(`CFCI_IDX_TX_COUNT, 32'h80, 32'hFF);
    apb(1'b1, `CFCI_IDX_TX_COUNT, 32'hF8);
    apb(1'b1, `CFCI_IDX_MODULE_CFG, 32'h0);
    pulse(12'h800, 16'h0);
    check(32'(fault_state), 32'h2, "bus-off");
    check(32'(bus_ctl.drive_enable), 32'h0, "bus released");
    check(32'(busoff_irq), 32'h1, "bus-off irq");
    rd_chk(`CFCI_IDX_TX_COUNT, 32'h00, 32'hFF);
    burst(1'b1, 12'd5);
    burst(1'b0, 12'd1);
    burst(1'b1, 12'd6);
    rd_chk(`CFCI_IDX_TX_COUNT, 32'h00, 32'hFF);
    burst(1'b1, 12'd5);
    rd_chk(`CFCI_IDX_TX_COUNT, 32'h01, 32'hFF);
    burst(1'b1, 12'd1397);
    check(32'(fault_state), 32'h0, "recovered");
    rd_chk(`CFCI_IDX_TX_COUNT, 32'h00, 32'hFF);
    rd_chk(`CFCI_IDX_RX_COUNT, 32'h00, 32'hFF);
    rd_chk(`CFCI_IDX_STATUS, 32'h4, 32'h4);
    apb(1'b1, `CFCI_IDX_STATUS, 32'h0);
    check(32'(busoff_irq), 32'h0, "bus-off cleared");
    apb(1'b1, `CFCI_IDX_MODULE_CFG, 32'h1);
    burst(1'b0, 12'd1);
    check(32'(wake_irq), 32'h0, "wake disabled");
    apb(1'b1, `CFCI_IDX_MODULE_CFG, 32'h3);
    burst(1'b0, 12'd1);
    check(32'(wake_irq), 32'h1, "wake");
    rd_chk(`CFCI_IDX_STATUS, 32'h1, 32'h1);
    apb(1'b1, `CFCI_IDX_STATUS, 32'h0);
    check(32'(wake_irq), 32'h0, "wake cleared");
    results();
  end
endmodule : tb
